// ===== design/iafd_defines.svh
`ifndef IAFD_DEFINES_SVH
`define IAFD_DEFINES_SVH

// Widths
`define IAFD_ADDR_W        8
`define IAFD_DATA_W        32
`define IAFD_RX_ABW        3
`define IAFD_TX_ABW        3
`define IAFD_LVL_W         4
`define IAFD_CAUSE_W       16
`define IAFD_RESP_W        8
`define IAFD_DCMD_W        9
`define IAFD_PIN_W         2

// Register offsets
`define IAFD_OFF_CLR_ALL   8'h40
`define IAFD_OFF_CLR_ABORT 8'h54
`define IAFD_OFF_RX_LEVEL  8'h78
`define IAFD_OFF_CAUSE     8'h80
`define IAFD_OFF_NACK      8'h84
`define IAFD_OFF_DMA       8'h88
`define IAFD_OFF_TX_WM     8'h8C
`define IAFD_OFF_RX_WM     8'h90

// Abort cause bit positions
`define IAFD_BIT_SEVEN_NAK 0
`define IAFD_BIT_TEN1_NAK  1
`define IAFD_BIT_TEN2_NAK  2
`define IAFD_BIT_DATA_NAK  3
`define IAFD_BIT_GC_NAK    4
`define IAFD_BIT_GC_READ   5
`define IAFD_BIT_HS_ACK    6
`define IAFD_BIT_SB_ACK    7
`define IAFD_BIT_HS_NORS   8
`define IAFD_BIT_SB_NORS   9
`define IAFD_BIT_TEN_RD    10
`define IAFD_BIT_MST_OFF   11
`define IAFD_BIT_ARBITRATION_LOST  12
`define IAFD_BIT_SLV_FLUSH 13
`define IAFD_BIT_SLV_LOST  14
`define IAFD_BIT_SLV_RDCMD 15

// Other field positions
`define IAFD_DMA_TX_BIT    1
`define IAFD_DMA_RX_BIT    0
`define IAFD_NACK_BIT      0
`define IAFD_CMD_READ_BIT  8
`define IAFD_PIN_SDA       0
`define IAFD_PIN_SCL       1

// Reset and constant values
`define IAFD_CAUSE_RST     16'h0000
`define IAFD_CAUSE_ALL     16'hFFFF
`define IAFD_WORD_ZERO     32'h0000_0000
`define IAFD_LVL_ZERO      4'h0
`define IAFD_LVL_ONE       4'h1
`define IAFD_RX_DEPTH      4'h8
`define IAFD_WM_RST        3'h0

`endif

// ===== design/iafd_pkg.sv
`include "iafd_defines.svh"

package iafd_pkg;

    typedef struct packed {
        logic [`IAFD_PIN_W-1:0] stage1;
        logic [`IAFD_PIN_W-1:0] stage2;
    } iafd_sync_t;

    typedef struct packed {
        logic [`IAFD_LVL_W-1:0] count;
    } iafd_lvl_t;

    typedef struct packed {
        logic [`IAFD_CAUSE_W-1:0] cause;
        logic                     irq;
        logic                     flushed;
        logic                     release_p;
        logic                     nack;
        logic                     tx_dma_enable;
        logic                     rx_dma_enable;
        logic [`IAFD_TX_ABW-1:0]  tx_wm;
        logic [`IAFD_RX_ABW-1:0]  rx_wm;
        logic                     scl_prev;
        logic [`IAFD_DATA_W-1:0]  prdata;
    } iafd_state_t;

endpackage

// ===== design/iafd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module iafd_sync
    import iafd_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [`IAFD_PIN_W-1:0] pin_in,
    output logic      [`IAFD_PIN_W-1:0] pin_sync
);

    iafd_sync_t s_q;
    iafd_sync_t s_d;

    // Two-stage capture of the bus pins
    always_comb
    begin
        s_d        = s_q;
        s_d.stage1 = pin_in;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            // Idle bus level, avoids a false edge after reset
            s_q <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q.stage2;

endmodule

`default_nettype wire

// ===== design/iafd_level.sv
`timescale 1ns/1ps
`default_nettype none

module iafd_level
    import iafd_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   clear,
    input  wire logic                   push,
    input  wire logic                   pop,
    output logic      [`IAFD_LVL_W-1:0] level
);

    iafd_lvl_t s_q;
    iafd_lvl_t s_d;

    always_comb
    begin
        s_d = s_q;
        // [RL1] Clear on disable or abort
        if (clear)
        begin
            s_d.count = `IAFD_LVL_ZERO;
        end
        // [RL2] Count pushes and pops
        else if (push && !pop && (s_q.count != `IAFD_RX_DEPTH))
        begin
            s_d.count = s_q.count + `IAFD_LVL_ONE;
        end
        else if (pop && !push && (s_q.count != `IAFD_LVL_ZERO))
        begin
            s_d.count = s_q.count - `IAFD_LVL_ONE;
        end
    end

    // [RL2] Reset to zero
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level = s_q.count;

endmodule

`default_nettype wire

// ===== design/iafd_top.sv
// Notes on behaviour
// [RL1] Receive level count clears when disabled or on any new abort cause.
// [RL2] Receive level counts pushes up, pops down, resets to zero.
// [RL3] Reading either clear register clears the abort cause bits.
// [RL4] Start-byte cause bit drops one cycle and returns while its cause persists.
// [RL5] Software removes the start-byte cause before clearing that bit.
// [RL6] Read command written while serving a remote read sets bit 15.
// [RL7] Slave transmit mismatch at SCL rise sets bits 14 and 12.
// [RL8] Remote read with stale transmit data sets bit 13 and flushes.
// [RL9] Master or slave arbitration loss sets bit 12.
// [RL10] Master start attempt with master mode off sets bit 11.
// [RL11] Ten-bit master read without restart sets bit 10.
// [RL12] Start byte attempt without restart sets bit 9.
// [RL13] High-speed master transfer without restart sets bit 8.
// [RL14] Acked start byte sets bit 7; acked high-speed code sets bit 6.
// [RL15] Read after general call sets bit 5; unacked general call bit 4.
// [RL16] Unacked data, ten-bit second, ten-bit first, seven-bit address set bits 3-0.
// [RL17] Forced NACK as slave receiver drops the byte instead of pushing it.
// [RL18] Forced NACK register exists only when its parameter is one.
// [RL19] DMA enables at bits 1 and 0, reset zero, writable at any time when HAS_DMA is set.
// [RL20] Without DMA the DMA registers ignore writes and read zero.
// [RL21] Transmit DMA request when enabled and transmit level at or below watermark.
// [RL22] Receive DMA request when enabled and level reaches watermark plus one.
// [RL23] Abort clear read releases the transmit FIFO flush.
// [RL24] Abort interrupt rises with any new cause bit, held until cleared.
`timescale 1ns/1ps
`default_nettype none

module iafd_top
    import iafd_pkg::*;
#(
    parameter bit                           HAS_DMA  = 1'b1,
    parameter bit                           HAS_NACK = 1'b1
)
(
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`IAFD_ADDR_W-1:0]    paddr,
    input  wire logic [`IAFD_DATA_W-1:0]    pwdata,
    output logic      [`IAFD_DATA_W-1:0]    prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ctrl_enable,
    input  wire logic                       restart_allow,
    input  wire logic                       target_special,
    input  wire logic                       gencall_or_startbyte_sel,
    input  wire logic                       master_mode_enable,
    input  wire logic                       master_start_req,
    input  wire logic                       master_sbyte_pending,
    input  wire logic                       master_10bit_read,
    input  wire logic                       master_hs_req,
    input  wire logic                       master_arbitration_lost,
    input  wire logic [`IAFD_RESP_W-1:0]    master_resp_events,
    input  wire logic                       slave_tx_active,
    input  wire logic                       slave_tx_drive_bit,
    input  wire logic                       slave_read_req,
    input  wire logic                       slave_rx_active,
    input  wire logic                       sda_pin,
    input  wire logic                       scl_pin,
    input  wire logic                       data_command_wr,
    input  wire logic [`IAFD_DCMD_W-1:0]    data_command_wdata,
    input  wire logic [`IAFD_LVL_W-1:0]     tx_level,
    input  wire logic                       rx_byte_push,
    input  wire logic                       rx_pop,
    output logic                            rx_push_accept,
    output logic                            slave_force_nack,
    output logic [`IAFD_LVL_W-1:0]          rx_level_count,
    output logic                            transmit_abort_irq,
    output logic                            tx_fifo_flush,
    output logic                            tx_fifo_release,
    output logic                            dma_tx_req,
    output logic                            dma_rx_req
);

    iafd_state_t                s_q;
    iafd_state_t                s_d;
    logic [`IAFD_PIN_W-1:0]     pins_raw;
    logic [`IAFD_PIN_W-1:0]     pins_sync;
    logic [`IAFD_CAUSE_W-1:0]   set_vec;
    logic [`IAFD_CAUSE_W-1:0]   new_set;
    logic [`IAFD_CAUSE_W-1:0]   clr_mask;
    logic                       any_new;
    logic                       rd_access;
    logic                       wr_access;
    logic                       rd_setup;
    logic                       clr_read;
    logic                       sbyte_cause;
    logic                       scl_rise;
    logic                       slave_lost;
    logic                       forced_nack_on;
    logic                       level_clear;

    function automatic logic iafd_hit(
        input logic [`IAFD_ADDR_W-1:0] addr,
        input logic [`IAFD_ADDR_W-1:0] offset
    );
        iafd_hit = (addr == offset);
    endfunction

    function automatic logic [`IAFD_DATA_W-1:0] iafd_read_word(
        input logic [`IAFD_ADDR_W-1:0] addr,
        input iafd_state_t             st,
        input logic [`IAFD_LVL_W-1:0]  lvl
    );
        logic [`IAFD_DATA_W-1:0] w;
        w = `IAFD_WORD_ZERO;
        if (iafd_hit(addr, `IAFD_OFF_RX_LEVEL))
        begin
            w = `IAFD_DATA_W'(lvl);
        end
        else if (iafd_hit(addr, `IAFD_OFF_CAUSE))
        begin
            w = `IAFD_DATA_W'(st.cause);
        end
        else if (iafd_hit(addr, `IAFD_OFF_NACK) && HAS_NACK)
        begin
            w[`IAFD_NACK_BIT] = st.nack;
        end
        else if (iafd_hit(addr, `IAFD_OFF_DMA) && HAS_DMA)
        begin
            w[`IAFD_DMA_TX_BIT] = st.tx_dma_enable;
            w[`IAFD_DMA_RX_BIT] = st.rx_dma_enable;
        end
        else if (iafd_hit(addr, `IAFD_OFF_TX_WM) && HAS_DMA)
        begin
            w = `IAFD_DATA_W'(st.tx_wm);
        end
        else if (iafd_hit(addr, `IAFD_OFF_RX_WM) && HAS_DMA)
        begin
            w = `IAFD_DATA_W'(st.rx_wm);
        end
        iafd_read_word = w;
    endfunction

    // Pin synchroniser
    assign pins_raw[`IAFD_PIN_SDA] = sda_pin;
    assign pins_raw[`IAFD_PIN_SCL] = scl_pin;

    iafd_sync u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .pin_in   (pins_raw),
        .pin_sync (pins_sync)
    );

    // Bus phases
    assign rd_setup  = psel && !penable && !pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign wr_access = psel && penable && pwrite;

    // [RL3] Clear by either clear register read
    assign clr_read = rd_access
                      && (iafd_hit(paddr, `IAFD_OFF_CLR_ABORT)
                          || iafd_hit(paddr, `IAFD_OFF_CLR_ALL));

    // [RL7] Mismatch at SCL rise
    assign scl_rise   = pins_sync[`IAFD_PIN_SCL] && !s_q.scl_prev;
    assign slave_lost = slave_tx_active && scl_rise
                        && (pins_sync[`IAFD_PIN_SDA] != slave_tx_drive_bit);

    // [RL12] Start byte cause level
    assign sbyte_cause = !restart_allow && target_special
                         && gencall_or_startbyte_sel && master_sbyte_pending;

    // Abort cause events
    always_comb
    begin
        set_vec = `IAFD_CAUSE_RST;
        // [RL14] Illegal response events
        // [RL15] General call events
        // [RL16] Master not-acked events
        set_vec[`IAFD_RESP_W-1:0] = master_resp_events;
        // [RL13] High speed no restart
        set_vec[`IAFD_BIT_HS_NORS] = master_hs_req && !restart_allow;
        // [RL12] Start byte no restart
        set_vec[`IAFD_BIT_SB_NORS] = sbyte_cause;
        // [RL11] Ten-bit read no restart
        set_vec[`IAFD_BIT_TEN_RD] = master_10bit_read && !restart_allow;
        // [RL10] Master mode disabled
        set_vec[`IAFD_BIT_MST_OFF] = master_start_req && !master_mode_enable;
        // [RL9] Arbitration lost either role
        set_vec[`IAFD_BIT_ARBITRATION_LOST] = master_arbitration_lost || slave_lost;
        // [RL8] Stale transmit data
        set_vec[`IAFD_BIT_SLV_FLUSH] = slave_read_req && (tx_level != `IAFD_LVL_ZERO);
        // [RL7] Slave bus lost
        set_vec[`IAFD_BIT_SLV_LOST] = slave_lost;
        // [RL6] Read command misuse
        set_vec[`IAFD_BIT_SLV_RDCMD] = slave_tx_active && data_command_wr
                                       && data_command_wdata[`IAFD_CMD_READ_BIT];
    end

    assign new_set  = set_vec & ~s_q.cause;
    assign any_new  = |new_set;
    assign clr_mask = clr_read ? `IAFD_CAUSE_ALL : `IAFD_CAUSE_RST;

    // [RL17] Forced NACK gating
    assign forced_nack_on = s_q.nack && slave_rx_active;
    assign rx_push_accept = rx_byte_push && !forced_nack_on;

    // [RL1] Level clear sources
    assign level_clear = !ctrl_enable || any_new;

    iafd_level u_level (
        .clk   (clk),
        .rstn  (rstn),
        .clear (level_clear),
        .push  (rx_push_accept),
        .pop   (rx_pop),
        .level (rx_level_count)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.scl_prev  = pins_sync[`IAFD_PIN_SCL];
        s_d.release_p = 1'b0;
        // [RL3] Clear then merge new causes
        // [RL4] Bit 9 drops in clear cycle
        s_d.cause = (s_q.cause & ~clr_mask)
                    | (set_vec & ~(clr_mask & (`IAFD_CAUSE_W'(1) << `IAFD_BIT_SB_NORS)));
        // [RL24] Interrupt flag, set wins
        if (any_new)
        begin
            s_d.irq = 1'b1;
        end
        else if (clr_read)
        begin
            s_d.irq = 1'b0;
        end
        // [RL8] Flush held until clear
        if (any_new)
        begin
            s_d.flushed = 1'b1;
        end
        else if (clr_read)
        begin
            // [RL23] Release transmit FIFO
            s_d.flushed   = 1'b0;
            s_d.release_p = 1'b1;
        end
        // Register writes
        if (wr_access)
        begin
            // [RL18] Forced NACK only when built
            if (iafd_hit(paddr, `IAFD_OFF_NACK) && HAS_NACK)
            begin
                s_d.nack = pwdata[`IAFD_NACK_BIT];
            end
            // [RL19] DMA enables writable at any time when HAS_DMA is set
            // [RL20] Absent without DMA
            if (iafd_hit(paddr, `IAFD_OFF_DMA) && HAS_DMA)
            begin
                s_d.tx_dma_enable = pwdata[`IAFD_DMA_TX_BIT];
                s_d.rx_dma_enable = pwdata[`IAFD_DMA_RX_BIT];
            end
            if (iafd_hit(paddr, `IAFD_OFF_TX_WM) && HAS_DMA)
            begin
                s_d.tx_wm = pwdata[`IAFD_TX_ABW-1:0];
            end
            if (iafd_hit(paddr, `IAFD_OFF_RX_WM) && HAS_DMA)
            begin
                s_d.rx_wm = pwdata[`IAFD_RX_ABW-1:0];
            end
        end
        // Read data captured in setup phase
        if (rd_setup)
        begin
            s_d.prdata = iafd_read_word(paddr, s_q, rx_level_count);
        end
    end

    // [RL19] Reset values zero
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q          <= '0;
            // Clock line idles high
            s_q.scl_prev <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.prdata;
    assign pready             = 1'b1;
    assign pslverr            = 1'b0;
    assign transmit_abort_irq = s_q.irq;
    assign tx_fifo_flush      = s_q.flushed;
    assign tx_fifo_release    = s_q.release_p;
    // [RL17] NACK after data byte
    assign slave_force_nack   = forced_nack_on;

    // [RL21] Transmit DMA request
    assign dma_tx_req = s_q.tx_dma_enable
                        && (tx_level <= {1'b0, s_q.tx_wm});
    // [RL22] Receive DMA request
    assign dma_rx_req = s_q.rx_dma_enable
                        && (rx_level_count >= ({1'b0, s_q.rx_wm} + `IAFD_LVL_ONE));

endmodule

`default_nettype wire

// ===== tb/iafd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module iafd_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       ctrl_enable,
    input wire logic       restart_allow,
    input wire logic       target_special,
    input wire logic       gencall_or_startbyte_sel,
    input wire logic       master_sbyte_pending,
    input wire logic       master_arbitration_lost,
    input wire logic [7:0] master_resp_events,
    input wire logic       rx_byte_push,
    input wire logic       rx_pop,
    input wire logic       rx_push_accept,
    input wire logic       slave_force_nack,
    input wire logic [3:0] rx_level_count,
    input wire logic       transmit_abort_irq,
    input wire logic       tx_fifo_flush,
    input wire logic       tx_fifo_release,
    input wire logic       dma_tx_req,
    input wire logic       dma_rx_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire sb = !restart_allow && target_special && gencall_or_startbyte_sel
        && master_sbyte_pending;
    wire clr = psel && penable && !pwrite && (paddr == 8'h54 || paddr == 8'h40);
    wire mev = master_arbitration_lost || (|master_resp_events);
    sequence s_sb;
        clr && sb ##1 sb;
    endsequence
    property p_rst;
        $rose(rstn) |-> rx_level_count == 4'h0 && !transmit_abort_irq && !dma_tx_req;
    endproperty
    property p_arb;
        master_arbitration_lost |=> transmit_abort_irq && tx_fifo_flush;
    endproperty
    property p_resp;
        (|master_resp_events) && !transmit_abort_irq |=> transmit_abort_irq
            && rx_level_count == 4'h0;
    endproperty
    property p_dis;
        !ctrl_enable |=> rx_level_count == 4'h0;
    endproperty
    property p_push;
        ctrl_enable && rx_push_accept && !rx_pop && rx_level_count < 4'h8
            |=> rx_level_count == $past(rx_level_count) + 4'h1 || rx_level_count == 4'h0;
    endproperty
    property p_pop;
        ctrl_enable && rx_pop && !rx_push_accept && rx_level_count != 4'h0
            |=> rx_level_count == $past(rx_level_count) - 4'h1 || rx_level_count == 4'h0;
    endproperty
    property p_nack;
        rx_push_accept == (rx_byte_push && !slave_force_nack);
    endproperty
    property p_rel;
        tx_fifo_release |-> !tx_fifo_flush && !transmit_abort_irq ##1 !tx_fifo_release;
    endproperty
    property p_clr;
        clr && !sb && !mev |=> !tx_fifo_flush && !transmit_abort_irq;
    endproperty
    property p_sb;
        s_sb |-> !transmit_abort_irq ##1 transmit_abort_irq;
    endproperty
    property p_dmarx;
        dma_rx_req |-> rx_level_count != 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not zero after reset");
    a_arb: assert property (p_arb) else $error("arbitration loss missed");
    a_resp: assert property (p_resp) else $error("response cause missed");
    a_dis: assert property (p_dis) else $error("level kept while disabled");
    a_push: assert property (p_push) else $error("push not counted");
    a_pop: assert property (p_pop) else $error("pop not counted");
    a_nack: assert property (p_nack) else $error("forced nack push wrong");
    a_rel: assert property (p_rel) else $error("release with flush");
    a_clr: assert property (p_clr) else $error("clear read ineffective");
    a_sb: assert property (p_sb) else $error("start byte bit not reasserted");
    a_dmarx: assert property (p_dmarx) else $error("rx request while empty");
endmodule
bind iafd_top iafd_chk u_chk (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .ctrl_enable, .restart_allow,
    .target_special, .gencall_or_startbyte_sel, .master_sbyte_pending, .master_arbitration_lost,
    .master_resp_events, .rx_byte_push, .rx_pop, .rx_push_accept, .slave_force_nack,
    .rx_level_count, .transmit_abort_irq, .tx_fifo_flush, .tx_fifo_release, .dma_tx_req,
    .dma_rx_req
);
`default_nettype wire

// ===== tb/iafd_far.sv
`timescale 1ns/1ps
`default_nettype none
module iafd_far (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic bit_in,
    input  wire logic wrong,
    output logic      sda,
    output logic      scl
);
    // Idle bus, both lines pulled high
    initial
    begin
        sda = 1'h1;
        scl = 1'h1;
    end
    // One bit time per request
    always @(posedge go)
    begin
        scl = 1'h0;
        repeat (2) @(posedge clk);
        sda = bit_in ^ wrong;
        repeat (2) @(posedge clk);
        scl = 1'h1;
        repeat (4) @(posedge clk);
        sda = 1'h1;
    end
endmodule
`default_nettype wire

// ===== tb/iafd_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rstn, psel, penable, pwrite, ctrl_enable, restart_allow, target_special;
    logic        gencall_or_startbyte_sel, master_mode_enable, master_start_req, go;
    logic        master_sbyte_pending, master_10bit_read, master_hs_req, master_arbitration_lost;
    logic        slave_tx_active, slave_tx_drive_bit, slave_read_req, slave_rx_active;
    logic        sda_pin, scl_pin, data_command_wr, rx_byte_push, rx_pop, pready, pslverr;
    logic        rx_push_accept, slave_force_nack, transmit_abort_irq, tx_fifo_flush;
    logic        tx_fifo_release, dma_tx_req, dma_rx_req, nk;
    logic [7:0]  paddr, master_resp_events;
    logic [8:0]  data_command_wdata;
    logic [3:0]  tx_level, rx_level_count;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h95EBDFA4;
    logic [7:0]  ad [7] = '{8'h78, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'hA0};
    logic [31:0] ex [7] = '{32'h0, 32'h0, 32'h1, 32'h3, 32'h7, 32'h7, 32'h0};
    int          err_total, n_checks, lvl, w, r;

    iafd_top uut (
        .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ctrl_enable, .restart_allow, .target_special, .gencall_or_startbyte_sel,
        .master_mode_enable, .master_start_req, .master_sbyte_pending, .master_10bit_read,
        .master_hs_req, .master_arbitration_lost, .master_resp_events, .slave_tx_active,
        .slave_tx_drive_bit, .slave_read_req, .slave_rx_active, .sda_pin, .scl_pin,
        .data_command_wr, .data_command_wdata, .tx_level, .rx_byte_push, .rx_pop,
        .rx_push_accept, .slave_force_nack, .rx_level_count, .transmit_abort_irq,
        .tx_fifo_flush, .tx_fifo_release, .dma_tx_req, .dma_rx_req
    );
    iafd_far far (.clk, .go, .bit_in(slave_tx_drive_bit), .wrong(1'h1), .sda(sda_pin),
        .scl(scl_pin));

    initial clk = 1'h0;
    always #2 clk = ~clk;

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} = {1'h1, wr, a, d};
        tick;
        penable = 1'h1;
        tick;
        rd = prdata;
        {psel, penable} = 2'h0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task rxstep(input logic pu, input logic po);
        {rx_byte_push, rx_pop} = {pu, po};
        tick;
        {rx_byte_push, rx_pop} = 2'h0;
        if (pu && !nk && !po && lvl < 8)
            lvl++;
        if (po && !(pu && !nk) && lvl > 0)
            lvl--;
        chk(rx_level_count, lvl);
    endtask
    task fire(input int k);
        tx_level = 4'h0;
        case (k)
            8: {restart_allow, master_hs_req} = 2'h1;
            10: {restart_allow, master_10bit_read} = 2'h1;
            11: {master_mode_enable, master_start_req} = 2'h1;
            12: master_arbitration_lost = 1'h1;
            13: {tx_level, slave_read_req} = 5'h5;
            14: {slave_tx_active, go} = 2'h3;
            15: {slave_tx_active, data_command_wr, data_command_wdata} = 11'h700;
            default: master_resp_events = 8'h01 << k;
        endcase
        tick;
        {master_hs_req, master_10bit_read, master_start_req, master_arbitration_lost} = 4'h0;
        {slave_read_req, data_command_wr, go, master_resp_events} = 11'h0;
        repeat (20)
            if (!transmit_abort_irq)
                tick;
        {restart_allow, master_mode_enable, slave_tx_active} = 3'h6;
    endtask
    task close_out;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata, target_special, nk} = '0;
        {gencall_or_startbyte_sel, master_start_req, master_sbyte_pending, go} = '0;
        {master_10bit_read, master_hs_req, master_arbitration_lost, master_resp_events} = '0;
        {slave_tx_active, slave_tx_drive_bit, slave_read_req, slave_rx_active} = '0;
        {data_command_wr, data_command_wdata, tx_level, rx_byte_push, rx_pop} = '0;
        {ctrl_enable, restart_allow, master_mode_enable} = 3'h7;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'h1;
        tick;
        for (int i = 0; i < 7; i++)
            rdchk(ad[i], 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'h1, ad[i], 32'hFFFFFFFF);
            rdchk(ad[i], ex[i]);
            apb(1'h1, ad[i], 32'h0);
        end
        apb(1'h1, 8'h88, 32'h3);
        w = xs() & 7;
        r = xs() & 7;
        apb(1'h1, 8'h8C, w);
        apb(1'h1, 8'h90, r);
        for (int t = 0; t <= 8; t++)
        begin
            tx_level = t[3:0];
            rxstep(1'h1, 1'h0);
            chk(dma_tx_req, t <= w);
            chk(dma_rx_req, lvl >= r + 1);
        end
        apb(1'h1, 8'h84, 32'h1);
        for (int i = 0; i < 60; i++)
        begin
            rd = xs();
            {slave_rx_active, nk} = {rd[2], rd[2]};
            rxstep(rd[0], rd[1]);
            chk(slave_force_nack, nk);
        end
        {slave_rx_active, nk, ctrl_enable} = '0;
        tick;
        lvl = 0;
        chk(rx_level_count, 32'h0);
        ctrl_enable = 1'h1;
        for (int k = 0; k < 16; k++)
        begin
            if (k == 9)
                continue;
            rxstep(1'h1, 1'h0);
            fire(k);
            lvl = 0;
            chk(transmit_abort_irq, 32'h1);
            chk(tx_fifo_flush, 32'h1);
            chk(rx_level_count, 32'h0);
            rdchk(8'h80, k == 14 ? 32'h5000 : 32'h1 << k);
            apb(1'h0, k[0] ? 8'h40 : 8'h54, 32'h0);
            chk(tx_fifo_release, 32'h1);
            chk(transmit_abort_irq, 32'h0);
            rdchk(8'h80, 32'h0);
        end
        {restart_allow, target_special, gencall_or_startbyte_sel, master_sbyte_pending} = 4'h7;
        tick;
        tick;
        rdchk(8'h80, 32'h200);
        apb(1'h0, 8'h54, 32'h0);
        chk(transmit_abort_irq, 32'h0);
        tick;
        chk(transmit_abort_irq, 32'h1);
        restart_allow = 1'h1;
        apb(1'h0, 8'h40, 32'h0);
        rdchk(8'h80, 32'h0);
        close_out;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out;
    end
endmodule
`default_nettype wire
